// File: hdl/isi_pkg.sv
// Package with register map, field positions and types for the two-wire slave
package isi_pkg;

  localparam logic [15:0] ADDR_RECEIVE_DATA      = 16'hf2a8;
  localparam logic [15:0] ADDR_OWN_SLAVE_ADDRESS = 16'hf2a9;
  localparam logic [15:0] ADDR_TRANSMIT_DATA     = 16'hf2aa;
  localparam logic [15:0] ADDR_TRANSFER_CONTROL  = 16'hf2ab;
  localparam logic [15:0] ADDR_MODE_CONFIG       = 16'hf2ac;
  localparam logic [15:0] ADDR_BUS_STATUS        = 16'hf2ad;

  // Byte addresses are printed offsets times four
  localparam int unsigned REG_INDEX_W = 16;
  localparam int unsigned APB_ADDR_W  = 18;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  localparam int unsigned CTL_WAIT_RELEASE   = 5;
  localparam int unsigned CTL_ACK_OUT_VALUE  = 7;
  localparam int unsigned MOD_IFACE_ENABLE   = 0;
  localparam int unsigned MOD_STOP_IRQ_EN    = 5;
  localparam int unsigned MOD_START_IRQ_EN   = 6;
  localparam logic [7:0]  MOD_WRITE_MASK     = 8'h61;
  localparam logic [7:0]  CTL_STORE_MASK     = 8'h80;

  typedef enum logic [1:0] {
    ISI_IDLE,
    ISI_ADDR,
    ISI_DATA,
    ISI_HOLD
  } isi_phase_e;

  typedef struct packed {
    logic transmit_direction;
    logic address_matched;
    logic tx_mismatch_error;
    logic ack_received;
    logic bus_busy_flag;
  } isi_status_s;

  typedef struct packed {
    logic scl_in;
    logic sda_in;
  } isi_pins_s;
endpackage

// File: hdl/isi_slave.sv
// Two-wire bus slave with APB register port
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module isi_slave
  import isi_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  scl_i,
  output logic                       scl_o,
  output logic                       scl_oe,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  output logic                       bus_irq
);

  // Register state
  logic [7:0]  receive_data;
  logic [7:0]  own_slave_address;
  logic [7:0]  transmit_data;
  logic [7:0]  transfer_control;
  logic [7:0]  mode_config;
  isi_status_s status;

  // Bus-side state
  isi_phase_e  phase;
  isi_phase_e  next_phase;
  logic [7:0]  shift;
  logic [3:0]  bit_cnt;
  logic        in_ack;
  logic        we_drive_ack;
  logic        tx_mode;
  logic        sda_drive_low;
  logic        muted;
  logic        holding;
  isi_pins_s   meta;
  isi_pins_s   sync;
  isi_pins_s   prev;

  // APB decode
  logic                   apb_access;
  logic                   wr_strobe;
  logic                   lane0;
  logic [REG_INDEX_W-1:0] reg_index;
  logic                   hit_rd;
  logic                   hit_sa;
  logic                   hit_td;
  logic                   hit_ctl;
  logic                   hit_mod;
  logic                   hit_stat;
  logic                   hit_any;
  logic                   wr_ctl;
  logic                   wr_mod;
  logic [7:0]             read_byte;
  logic                   enabled;

  assign apb_access = psel && penable;
  assign wr_strobe  = apb_access && pwrite;
  assign lane0      = pstrb[0];
  assign reg_index  = paddr[APB_ADDR_W-1:2];
  assign hit_rd     = (reg_index == ADDR_RECEIVE_DATA) && (paddr[1:0] == 2'b00);
  assign hit_sa     = (reg_index == ADDR_OWN_SLAVE_ADDRESS) && (paddr[1:0] == 2'b00);
  assign hit_td     = (reg_index == ADDR_TRANSMIT_DATA) && (paddr[1:0] == 2'b00);
  assign hit_ctl    = (reg_index == ADDR_TRANSFER_CONTROL) && (paddr[1:0] == 2'b00);
  assign hit_mod    = (reg_index == ADDR_MODE_CONFIG) && (paddr[1:0] == 2'b00);
  assign hit_stat   = (reg_index == ADDR_BUS_STATUS) && (paddr[1:0] == 2'b00);
  assign hit_any    = hit_rd || hit_sa || hit_td || hit_ctl || hit_mod || hit_stat;
  assign wr_ctl     = wr_strobe && hit_ctl && lane0;
  assign wr_mod     = wr_strobe && hit_mod && lane0;
  assign enabled    = mode_config[MOD_IFACE_ENABLE];

  always_comb begin
    if (hit_rd) begin
      read_byte = receive_data;
    end else if (hit_sa) begin
      read_byte = {own_slave_address[7:1], 1'b0};
    end else if (hit_td) begin
      read_byte = transmit_data;
    end else if (hit_ctl) begin
      read_byte = transfer_control & CTL_STORE_MASK; // wait release reads zero
    end else if (hit_mod) begin
      read_byte = mode_config;
    end else if (hit_stat) begin
      read_byte = {3'b000, status};
    end else begin
      read_byte = RESET_BYTE;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = apb_access && !hit_any;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

  // Pin synchroniser: meta feeds only sync
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta <= '1;
      sync <= '1;
      prev <= '1;
    end else begin
      meta <= '{scl_in: scl_i, sda_in: sda_i};
      sync <= meta;
      prev <= sync;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_hit;
  logic byte_done;
  logic ack_slot_fall;
  logic wait_release_req;
  logic bit_mismatch;

  assign scl_rise  = sync.scl_in && !prev.scl_in;
  assign scl_fall  = !sync.scl_in && prev.scl_in;
  assign start_det = enabled && sync.scl_in && prev.scl_in && prev.sda_in && !sync.sda_in;
  assign stop_det  = enabled && sync.scl_in && prev.scl_in && !prev.sda_in && sync.sda_in;
  assign byte_done = scl_rise && (bit_cnt == 4'd7) && !in_ack;
  // Address compare uses the 7 upper bits only
  assign addr_hit  = (phase == ISI_ADDR) && byte_done && ({shift[6:0]} == own_slave_address[7:1]);
  // Only the fall that ends the ack slot; the fall into it does not count
  assign ack_slot_fall    = scl_fall && in_ack && (bit_cnt == 4'd9);
  assign wait_release_req = wr_ctl && pwdata[CTL_WAIT_RELEASE];
  // Mismatch check on data bits driven by us only; the ack slot is not checked
  assign bit_mismatch = scl_rise && !in_ack && tx_mode && (phase == ISI_DATA) && !muted &&
                        (sync.sda_in != shift[7]);

  // Control registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      own_slave_address <= RESET_BYTE;
      transmit_data     <= RESET_BYTE;
      transfer_control  <= RESET_BYTE;
      mode_config       <= RESET_BYTE;
    end else begin
      if (wr_mod) begin
        mode_config <= pwdata[7:0] & MOD_WRITE_MASK;
      end
      if (!enabled && !(wr_mod && pwdata[MOD_IFACE_ENABLE])) begin
        own_slave_address <= RESET_BYTE;
        transmit_data     <= RESET_BYTE;
        transfer_control  <= RESET_BYTE;
      end else begin
        if (wr_strobe && hit_sa && lane0) begin
          own_slave_address <= {pwdata[7:1], 1'b0};
        end
        if (wr_strobe && hit_td && lane0) begin
          transmit_data <= pwdata[7:0];
        end
        if (wr_ctl) begin
          transfer_control <= pwdata[7:0] & CTL_STORE_MASK;
        end
      end
    end
  end

  // Serial state machine
  always_comb begin
    next_phase = phase;
    case (phase)
      ISI_IDLE: begin
        next_phase = ISI_IDLE;
      end
      ISI_ADDR: begin
        if (byte_done && !addr_hit) begin
          next_phase = ISI_IDLE;
        end else if (ack_slot_fall) begin
          next_phase = ISI_HOLD;
        end
      end
      ISI_DATA: begin
        if (ack_slot_fall) begin
          next_phase = ISI_HOLD;
        end
      end
      ISI_HOLD: begin
        if (wait_release_req) begin
          next_phase = ISI_DATA;
        end
      end
      default: begin
        next_phase = ISI_IDLE;
      end
    endcase
    if (start_det) begin
      next_phase = ISI_ADDR;
    end else if (stop_det || !enabled) begin
      next_phase = ISI_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || !enabled) begin
      phase         <= ISI_IDLE;
      shift         <= RESET_BYTE;
      bit_cnt       <= 4'd0;
      in_ack        <= 1'b0;
      we_drive_ack  <= 1'b0;
      tx_mode       <= 1'b0;
      sda_drive_low <= 1'b0;
      muted         <= 1'b0;
      receive_data  <= RESET_BYTE;
      status        <= '0;
    end else begin
      phase <= next_phase;
      if (wr_ctl) begin
        status.tx_mismatch_error <= 1'b0;
      end
      if (bit_mismatch) begin
        status.tx_mismatch_error <= 1'b1; // set wins over clear
        muted                    <= 1'b1;
        sda_drive_low            <= 1'b0;
      end
      if (start_det) begin
        status.bus_busy_flag      <= 1'b1;
        status.transmit_direction <= 1'b0;
        bit_cnt       <= 4'd0;
        in_ack        <= 1'b0;
        tx_mode       <= 1'b0;
        sda_drive_low <= 1'b0;
        muted         <= 1'b0;
      end else if (stop_det) begin
        status.bus_busy_flag      <= 1'b0;
        status.transmit_direction <= 1'b0;
        in_ack        <= 1'b0;
        sda_drive_low <= 1'b0;
        muted         <= 1'b0;
      end else if (phase == ISI_ADDR || phase == ISI_DATA) begin
        if (scl_rise && !in_ack) begin
          shift <= {shift[6:0], sync.sda_in};
          if (bit_cnt == 4'd7) begin
            in_ack <= 1'b1;
            // Captured on own transmissions too
            receive_data <= {shift[6:0], sync.sda_in};
          end
          bit_cnt <= bit_cnt + 4'd1;
        end else if (scl_rise && in_ack) begin
          status.ack_received <= sync.sda_in;
        end
        if (addr_hit) begin
          status.address_matched    <= 1'b1;
          status.transmit_direction <= sync.sda_in;
          tx_mode                   <= sync.sda_in;
        end
        if (scl_fall) begin
          if (byte_done || (bit_cnt == 4'd8 && !in_ack)) begin
            sda_drive_low <= 1'b0;
          end else if (in_ack && bit_cnt == 4'd8) begin
            // Falling edge into the ack slot
            bit_cnt <= 4'd9;
            we_drive_ack <= !tx_mode || (phase == ISI_ADDR);
            sda_drive_low <= (phase == ISI_ADDR) ||
                             (!tx_mode && !transfer_control[CTL_ACK_OUT_VALUE] && !muted);
          end else if (in_ack) begin
            // End of ack slot: release and mute ends with the byte
            in_ack        <= 1'b0;
            bit_cnt       <= 4'd0;
            sda_drive_low <= 1'b0;
            muted         <= 1'b0;
          end else if (tx_mode && phase == ISI_DATA) begin
            sda_drive_low <= !muted && !shift[7];
          end
        end
      end
      if (phase == ISI_HOLD && wait_release_req && tx_mode) begin
        // Load next byte and present its MSB while clock is still low
        shift         <= transmit_data;
        sda_drive_low <= !transmit_data[7];
        muted         <= 1'b0;
      end
    end
  end

  // Hold clock low in the waiting state
  assign holding = (phase == ISI_HOLD);
  assign scl_o   = 1'b0;
  assign scl_oe  = holding;
  assign sda_o   = 1'b0;
  assign sda_oe  = sda_drive_low;

  // Interrupt pulse on entering wait, start or stop
  always_ff @(posedge clock) begin
    if (sys_rst || !enabled) begin
      bus_irq <= 1'b0;
    end else begin
      bus_irq <= (phase != ISI_HOLD && next_phase == ISI_HOLD) ||
                 (start_det && mode_config[MOD_START_IRQ_EN]) ||
                 (stop_det && mode_config[MOD_STOP_IRQ_EN]);
    end
  end

endmodule
`default_nettype wire

// File: testbench/isi_mst.sv
// Behavioural two-wire bus master driving open-drain line enables
`timescale 1ns/1ps
`default_nettype none
module isi_mst (
  input  wire logic clock,
  input  wire logic scl,
  input  wire logic sda,
  output var logic  m_scl_oe,
  output var logic  m_sda_oe
);
  initial m_scl_oe = 1'b0;
  initial m_sda_oe = 1'b0;
  // Half of the 320 ns clock-low time, fixed rate only
  task automatic hp;
    repeat (4) @(posedge clock);
  endtask
  task automatic bit_c(input logic low, output logic seen);
    m_sda_oe <= low;
    hp();
    m_scl_oe <= 1'b0;
    @(posedge clock);
    while (!scl) @(posedge clock);
    hp();
    seen = sda;
    m_scl_oe <= 1'b1;
    hp();
  endtask
  task automatic start_c;
    m_sda_oe <= 1'b1;
    hp();
    m_scl_oe <= 1'b1;
    hp();
  endtask
  task automatic stop_c;
    m_sda_oe <= 1'b1;
    hp();
    m_scl_oe <= 1'b0;
    @(posedge clock);
    while (!scl) @(posedge clock);
    hp();
    m_sda_oe <= 1'b0;
    hp();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(!d[i], s);
    bit_c(1'b0, ack);
  endtask
  // Clobber bits pull the line low to provoke a collision
  task automatic rbyte(input logic [7:0] cl, input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(cl[i], s);
      d[i] = s;
    end
    bit_c(!nack, s);
  endtask
endmodule
`default_nettype wire

// File: testbench/isi_slave_sva.sv
// Port checker for the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module isi_slave_sva
  import isi_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  scl_i,
  input wire logic                  scl_o,
  input wire logic                  scl_oe,
  input wire logic                  sda_i,
  input wire logic                  sda_o,
  input wire logic                  sda_oe,
  input wire logic                  bus_irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire logic        acc = psel && penable;
  wire logic        wr  = acc && pwrite && pstrb[0];
  wire logic [15:0] idx = paddr[17:2];
  wire logic        map = paddr[1:0] == 2'b00 && idx >= ADDR_RECEIVE_DATA && idx <= ADDR_BUS_STATUS;
  sequence s_release;
    wr && idx == ADDR_TRANSFER_CONTROL && pwdata[CTL_WAIT_RELEASE] && scl_oe;
  endsequence
  sequence s_disable;
    wr && idx == ADDR_MODE_CONFIG && !pwdata[MOD_IFACE_ENABLE];
  endsequence
  property p_reset_quiet;
    $fell(sys_rst) |-> !scl_oe && !sda_oe && !bus_irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_release;
    s_release |=> ##[0:2] !scl_oe;
  endproperty
  a_release: assert property (p_release) else $error("clock hold not released");
  // Any write that could end the hold is excluded, the rest must keep it
  property p_hold;
    scl_oe && !(wr && (pwdata[CTL_WAIT_RELEASE] || idx == ADDR_MODE_CONFIG)) |=> scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("clock hold dropped");
  property p_disable;
    s_disable |=> ##[0:1] (!scl_oe && !sda_oe);
  endproperty
  a_disable: assert property (p_disable) else $error("lines driven while disabled");
  property p_irq_pulse;
    bus_irq |=> !bus_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a cycle");
  property p_wait_irq;
    $rose(scl_oe) |-> ##[0:2] bus_irq;
  endproperty
  a_wait_irq: assert property (p_wait_irq) else $error("no interrupt on wait entry");
  property p_stretch_low;
    $rose(scl_oe) |-> !scl_i;
  endproperty
  a_stretch_low: assert property (p_stretch_low) else $error("hold began with clock high");
  property p_data_low_phase;
    $rose(sda_oe) |-> !scl_i;
  endproperty
  a_data_low_phase: assert property (p_data_low_phase) else $error("data driven with clock high");
  property p_open_drain;
    !scl_o && !sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_map;
    acc |-> pready && pslverr == !map;
  endproperty
  a_map: assert property (p_map) else $error("bad answer to access");
  property p_ctl_read;
    acc && !pwrite && idx == ADDR_TRANSFER_CONTROL |-> !prdata[CTL_WAIT_RELEASE] && prdata[31:8] == 24'h00_0000;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("release bit read as one");
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Bench for the two-wire slave: registers, address match, transfers
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top
  import isi_pkg::*;
();
  logic                  clock   = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [APB_ADDR_W-1:0] paddr   = '0;
  logic                  psel    = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite  = 1'b0;
  logic [31:0]           pwdata  = '0;
  logic [3:0]            pstrb   = 4'h1;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  scl_oe;
  logic                  sda_oe;
  logic                  bus_irq;
  logic                  m_scl_oe;
  logic                  m_sda_oe;
  wire logic             scl_i = !(scl_oe | m_scl_oe);
  wire logic             sda_i = !(sda_oe | m_sda_oe);
  int                    n_errors;
  int                    checked;
  int                    n_irq;
  int                    i0;
  logic [7:0]            rdv;
  logic                  erv;
  logic [6:0]            sa;
  logic [7:0]            t;
  logic [7:0]            cl;
  logic [7:0]            b;
  logic                  ack;
  isi_slave u_isi_slave (.scl_o(), .sda_o(), .*);
  isi_mst u_isi_mst (.clock, .scl(scl_i), .sda(sda_i), .m_scl_oe, .m_sda_oe);
  always #20 clock = ~clock;
  always @(posedge clock) if (bus_irq === 1'b1) n_irq++;
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {a, 2'b00};
    pwdata  <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdv = prdata[7:0];
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    apb(1'b0, a, 8'h00);
    `CK($sformatf("reg %h", a), e, rdv & m)
  endtask
  task automatic stat(input logic [7:0] e, input logic [7:0] m = 8'hff);
    rchk(ADDR_BUS_STATUS, e, m);
  endtask
  task automatic ctl(input logic [7:0] d);
    apb(1'b1, ADDR_TRANSFER_CONTROL, d);
  endtask
  task automatic idle;
    repeat (8) @(posedge clock);
  endtask
  task automatic all_zero;
    for (int i = 0; i < 6; i++) rchk(ADDR_RECEIVE_DATA + 16'(i), 8'h00);
  endtask
  // Line value once the slave gives up driving after a collision
  function automatic logic [7:0] on_wire(input logic [7:0] d, input logic [7:0] c);
    logic e;
    e = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      on_wire[i] = (e | d[i]) & ~c[i];
      e |= d[i] & c[i];
    end
  endfunction
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'he3ac));
    sa = 7'($urandom);
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    all_zero();
    apb(1'b0, 16'hf2ae, 8'h00);
    `CK("unmapped error", 1'b1, erv)
    apb(1'b1, ADDR_OWN_SLAVE_ADDRESS, 8'hfe);
    rchk(ADDR_OWN_SLAVE_ADDRESS, 8'h00);
    apb(1'b1, ADDR_MODE_CONFIG, 8'h61);
    rchk(ADDR_MODE_CONFIG, 8'h61);
    apb(1'b1, ADDR_OWN_SLAVE_ADDRESS, {sa, 1'b1});
    rchk(ADDR_OWN_SLAVE_ADDRESS, {sa, 1'b0}, 8'hfe);
    ctl(8'ha0);
    rchk(ADDR_TRANSFER_CONTROL, 8'h80);
    $display("test registers done");
    i0 = n_irq;
    u_isi_mst.start_c();
    u_isi_mst.wbyte({sa ^ 7'h15, 1'b0}, ack);
    `CK("mismatch ack", 1'b1, ack)
    idle();
    `CK("mismatch hold", 1'b0, scl_oe)
    stat(8'h01);
    u_isi_mst.stop_c();
    stat(8'h00);
    `CK("irq count", 2, n_irq - i0)
    $display("test mismatch done");
    i0 = n_irq;
    u_isi_mst.start_c();
    u_isi_mst.wbyte({sa, 1'b0}, ack);
    `CK("match ack", 1'b0, ack)
    idle();
    `CK("wait hold", 1'b1, scl_oe)
    stat(8'h09);
    `CK("irq count", 2, n_irq - i0)
    ctl(8'ha0);
    t = 8'($urandom);
    u_isi_mst.wbyte(t, ack);
    `CK("data ack", 1'b1, ack)
    idle();
    rchk(ADDR_RECEIVE_DATA, t);
    stat(8'h0b);
    ctl(8'h20);
    u_isi_mst.stop_c();
    stat(8'h00, 8'h11);
    $display("test receive done");
    apb(1'b1, ADDR_MODE_CONFIG, 8'h01);
    i0 = n_irq;
    u_isi_mst.start_c();
    u_isi_mst.wbyte({sa, 1'b1}, ack);
    idle();
    stat(8'h19);
    t = 8'($urandom);
    apb(1'b1, ADDR_TRANSMIT_DATA, t);
    ctl(8'h20);
    u_isi_mst.rbyte(8'h00, 1'b0, b);
    `CK("read byte", t, b)
    idle();
    rchk(ADDR_RECEIVE_DATA, t);
    t = 8'($urandom) | 8'h80;
    cl = 8'h80 | (8'($urandom) & 8'h0f);
    apb(1'b1, ADDR_TRANSMIT_DATA, t);
    ctl(8'h20);
    u_isi_mst.rbyte(cl, 1'b1, b);
    `CK("collided byte", on_wire(t, cl), b)
    idle();
    rchk(ADDR_RECEIVE_DATA, on_wire(t, cl));
    stat(8'h1f);
    ctl(8'h00);
    stat(8'h1b);
    `CK("irq count", 3, n_irq - i0)
    apb(1'b1, ADDR_TRANSMIT_DATA, 8'hff);
    ctl(8'h20);
    u_isi_mst.stop_c();
    $display("test transmit done");
    apb(1'b1, ADDR_MODE_CONFIG, 8'h00);
    all_zero();
    $display("test disable done");
    summarize();
  end
endmodule
bind isi_slave isi_slave_sva u_isi_slave_sva (.*);
`default_nettype wire
